// File: common/plsm_pkg.sv
// Shared constants for the process load and stall monitor
package plsm_pkg;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_OVL_TIME = 8'h04;
   localparam logic [7:0] A_OVL_THR = 8'h08;
   localparam logic [7:0] A_HYST = 8'h0c;
   localparam logic [7:0] A_UL_TIME = 8'h10;
   localparam logic [7:0] A_UL_FREQ = 8'h14;
   localparam logic [7:0] A_RESTART = 8'h18;
   localparam logic [7:0] A_STALL_TIME = 8'h1c;
   localparam logic [7:0] A_STALL_CUR = 8'h20;
   localparam logic [7:0] A_STALL_FREQ = 8'h24;
   localparam logic [7:0] A_RATED = 8'h28;
   localparam logic [7:0] A_STATUS = 8'h2c;
   localparam logic [7:0] A_MASK = 8'h30;
   localparam logic [7:0] A_STATE = 8'h34;
   // Control word fields
   localparam int F_UL_REACT = 0;
   localparam int F_OL_REACT = 2;
   localparam int F_STALL_EN = 4;
   localparam int F_LOCK_CLR = 5;
   // Restart word fields
   localparam int F_UL_DELAY = 0;
   localparam int F_OL_DELAY = 4;
   localparam int F_RESET_TIME = 8;
   // Reaction codes
   localparam logic [1:0] REACT_IGNORE = 2'h0;
   localparam logic [1:0] REACT_FREEWHEEL = 2'h1;
   localparam logic [1:0] RAMP_HALT_CODE = 2'h2;
   localparam logic [1:0] QUICK_HALT_CODE = 2'h3;
   // Status bits
   localparam int ST_OVL = 0;
   localparam int ST_UL = 1;
   localparam int ST_STALL = 2;
   localparam int ST_W = 3;
   // Reset values and ranges; times in s, 0.1 s or min, frequencies in 0.1 Hz, current in % or 0.1 %
   localparam logic [6:0] OVL_TIME_RST = 7'h00;
   localparam logic [6:0] OVL_TIME_MAX = 7'h64;
   localparam logic [7:0] OVL_THR_RST = 8'h6e;
   localparam logic [7:0] OVL_THR_MIN = 8'h46;
   localparam logic [7:0] OVL_THR_MAX = 8'h96;
   localparam logic [12:0] HYST_RST = 13'h0003;
   localparam logic [12:0] HYST_MAX = 13'h1388;
   localparam logic [6:0] UL_TIME_RST = 7'h00;
   localparam logic [12:0] UL_FREQ_RST = 13'h0000;
   localparam logic [2:0] DELAY_RST = 3'h0;
   localparam logic [2:0] DELAY_MAX = 3'h6;
   localparam logic [7:0] RESET_TIME_RST = 8'h05;
   localparam logic [10:0] STALL_TIME_RST = 11'h258;
   localparam logic [10:0] STALL_TIME_MAX = 11'h7d0;
   localparam logic [10:0] STALL_CUR_RST = 11'h5dc;
   localparam logic [10:0] STALL_CUR_MAX = 11'h5dc;
   localparam logic [12:0] STALL_FREQ_RST = 13'h0014;
   localparam logic [12:0] MAX_FREQ = 13'h1388;
   localparam logic [15:0] RATED_RST = 16'h03e8;
   // Time base
   localparam int CLK_HZ = 125000000;
   localparam int TICK_TIME_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
   localparam logic [3:0] TICKS_PER_S = 4'ha;
   localparam logic [9:0] TICKS_PER_MIN = 10'h258;
   typedef enum logic [2:0] {
      MON_RUN = 3'b001,
      MON_HALT = 3'b010,
      MON_LOCK = 3'b100
   } mon_state_e;
endpackage

// File: rtl/persist_timer.sv
// Persistence counter that declares a fault once a condition has lasted long enough
`timescale 1ns/10ps
module persist_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic cond,
   input wire logic tick,
   input wire logic [15:0] limit,
   input wire logic strict,
   output logic hit
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   wire at_top = (cnt_reg == 16'hffff);

   // Count restarts from zero each time the condition drops
   assign cnt_next = !cond ? 16'h0000 : ((tick && !at_top) ? cnt_reg + 16'h0001 : cnt_reg);
   assign hit = cond && (strict ? (cnt_reg > limit) : (cnt_reg >= limit));

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule

// File: rtl/process_load_stall_monitor.sv
// Process overload, underload reaction and motor stall monitor with AHB-Lite registers
//
// Behaviour
// - Underload detection applies selected reaction: ignore, freewheel (default), ramp or quick stop.
// - Hold off restart for underload delay; restart only if reset time is at least delay+1min.
// - Underload restart delay writable only while underload reaction is not ignore.
// - Overload flagged when current limit or steady overcurrent persists for detect time.
// - Steady state when reference and motor frequency differ by less than hysteresis.
// - Overload monitoring stays active whenever the drive is in current limitation.
// - Overload detect time 0..100 s, default 0; zero disables and locks its settings.
// - Overload threshold is percent of rated current, 70..150, default 110.
// - Overload applies selected reaction, default freewheel; writable only with nonzero time.
// - Hold off restart for overload delay 0..6 min; reset time must exceed by 1min.
// - Stall error when frequency low and current high for longer than stall time.
// - Stall monitoring has enable setting, disabled by default.
// - Stall time 0..200 s, default 60 s, writable only while stall enabled.
// - Stall current is percent of rated current, 0..150, default 150.
// - Stall frequency ranges up to maximum frequency, default 2.0 Hz.
// - Underload detector inactive while motor frequency below minimum detection frequency.
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module process_load_stall_monitor
   import plsm_pkg::*;
#(
   parameter int TICK_COUNT = TICK_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [15:0] MOTOR_CURRENT_MEASURED,
   input wire logic [15:0] MOTOR_OUTPUT_FREQ,
   input wire logic [15:0] PRE_RAMP_REFERENCE_FREQ,
   input wire logic CURRENT_LIMIT_STATE,
   input wire logic UNDERLOAD_TORQUE_LOW,
   output logic [1:0] HALT_CODE,
   output logic OVERLOAD_FAULT,
   output logic UNDERLOAD_FAULT,
   output logic MOTOR_STALL_ERROR,
   output logic IRQ
);
   // Settings
   logic [1:0] underload_reaction_select_reg;
   logic [1:0] overload_reaction_select_reg;
   logic stall_monitor_enable_reg;
   logic [6:0] overload_detect_time_reg;
   logic [7:0] overload_current_threshold_reg;
   logic [12:0] steady_state_hysteresis_reg;
   logic [6:0] underload_detect_time_reg;
   logic [12:0] underload_min_freq_reg;
   logic [2:0] underload_restart_delay_reg;
   logic [2:0] overload_restart_delay_reg;
   logic [7:0] fault_reset_time_reg;
   logic [10:0] stall_max_time_reg;
   logic [10:0] stall_current_threshold_reg;
   logic [12:0] stall_frequency_threshold_reg;
   logic [15:0] rated_motor_current_reg;
   logic [ST_W-1:0] status_reg;
   logic [ST_W-1:0] mask_reg;

   // Bus pipeline
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] rdata_reg;
   wire take = HSEL && HREADY && HTRANS[1];
   wire wr_req = take && HWRITE;
   wire rd_req = take && !HWRITE;
   wire [7:0] rd_addr = HADDR[7:0];
   wire [31:0] wd = HWDATA;

   // Write strobes, one per writable register (none for A_STATE), valid in the data phase
   wire wr_ctrl = wr_pend_reg && (wr_addr_reg == A_CTRL);
   wire wr_ovl_time = wr_pend_reg && (wr_addr_reg == A_OVL_TIME);
   wire wr_ovl_thr = wr_pend_reg && (wr_addr_reg == A_OVL_THR);
   wire wr_hyst = wr_pend_reg && (wr_addr_reg == A_HYST);
   wire wr_ul_time = wr_pend_reg && (wr_addr_reg == A_UL_TIME);
   wire wr_ul_freq = wr_pend_reg && (wr_addr_reg == A_UL_FREQ);
   wire wr_restart = wr_pend_reg && (wr_addr_reg == A_RESTART);
   wire wr_st_time = wr_pend_reg && (wr_addr_reg == A_STALL_TIME);
   wire wr_st_cur = wr_pend_reg && (wr_addr_reg == A_STALL_CUR);
   wire wr_st_freq = wr_pend_reg && (wr_addr_reg == A_STALL_FREQ);
   wire wr_rated = wr_pend_reg && (wr_addr_reg == A_RATED);
   wire wr_status = wr_pend_reg && (wr_addr_reg == A_STATUS);
   wire wr_mask = wr_pend_reg && (wr_addr_reg == A_MASK);

   // Gating of dependent settings; out-of-range values are dropped, not clamped
   wire ol_on = (overload_detect_time_reg != 7'h00);
   wire ul_on = (underload_detect_time_reg != 7'h00);
   wire ul_react_on = (underload_reaction_select_reg != REACT_IGNORE);
   wire lock_clr = wr_ctrl && wd[F_LOCK_CLR];
   wire ok_ovl_time = wr_ovl_time && (wd[6:0] <= OVL_TIME_MAX) && (wd[31:7] == 25'h0);
   wire ok_ovl_thr = wr_ovl_thr && ol_on && (wd[7:0] >= OVL_THR_MIN) && (wd[7:0] <= OVL_THR_MAX)
      && (wd[31:8] == 24'h0);
   wire ok_hyst = wr_hyst && (ol_on || ul_on) && (wd[12:0] >= HYST_RST) && (wd[12:0] <= HYST_MAX)
      && (wd[31:13] == 19'h0);
   wire ok_ul_time = wr_ul_time && (wd[6:0] <= OVL_TIME_MAX) && (wd[31:7] == 25'h0);
   wire ok_ul_freq = wr_ul_freq && ul_on && (wd[12:0] <= HYST_MAX) && (wd[31:13] == 19'h0);
   wire ok_ul_delay = wr_restart && ul_react_on && (wd[F_UL_DELAY+:3] <= DELAY_MAX);
   wire ok_ol_delay = wr_restart && ol_on && (wd[F_OL_DELAY+:3] <= DELAY_MAX);
   wire ok_st_time = wr_st_time && stall_monitor_enable_reg && (wd[10:0] <= STALL_TIME_MAX)
      && (wd[31:11] == 21'h0);
   wire ok_st_cur = wr_st_cur && stall_monitor_enable_reg && (wd[10:0] <= STALL_CUR_MAX)
      && (wd[31:11] == 21'h0);
   wire ok_st_freq = wr_st_freq && stall_monitor_enable_reg && (wd[12:0] <= MAX_FREQ)
      && (wd[31:13] == 19'h0);

   // 100 ms time base; all persistence and hold-off counters step on it
   logic [23:0] pre_reg;
   logic tick_reg;
   wire pre_end = (pre_reg == 24'(TICK_COUNT - 1));

   // Steady state and comparisons
   wire [15:0] freq_diff = (PRE_RAMP_REFERENCE_FREQ >= MOTOR_OUTPUT_FREQ) ?
      PRE_RAMP_REFERENCE_FREQ - MOTOR_OUTPUT_FREQ : MOTOR_OUTPUT_FREQ - PRE_RAMP_REFERENCE_FREQ;
   wire steady = (freq_diff < {3'h0, steady_state_hysteresis_reg});
   wire [27:0] cur_x100 = 28'(MOTOR_CURRENT_MEASURED) * 28'd100;
   wire [27:0] cur_x1000 = 28'(MOTOR_CURRENT_MEASURED) * 28'd1000;
   wire [27:0] ovl_lim = 28'(overload_current_threshold_reg) * 28'(rated_motor_current_reg);
   wire [27:0] st_lim = 28'(stall_current_threshold_reg) * 28'(rated_motor_current_reg);
   // Current limitation counts at any time, not only while ramping
   wire ol_cond = ol_on && (CURRENT_LIMIT_STATE || (steady && (cur_x100 > ovl_lim)));
   wire ul_cond = ul_on && steady && UNDERLOAD_TORQUE_LOW
      && (MOTOR_OUTPUT_FREQ >= {3'h0, underload_min_freq_reg});
   wire st_cond = stall_monitor_enable_reg && (MOTOR_OUTPUT_FREQ < {3'h0, stall_frequency_threshold_reg})
      && (cur_x1000 > st_lim);

   wire ol_hit;
   wire ul_hit;
   wire st_hit;
   logic [2:0] hit_d_reg;

   persist_timer u_ol_timer (
      .clk(SYS_CLK),
      .rst(RST),
      .cond(ol_cond),
      .tick(tick_reg),
      .limit(16'(overload_detect_time_reg) * 16'(TICKS_PER_S)),
      .strict(1'b0),
      .hit(ol_hit)
   );
   persist_timer u_ul_timer (
      .clk(SYS_CLK),
      .rst(RST),
      .cond(ul_cond),
      .tick(tick_reg),
      .limit(16'(underload_detect_time_reg) * 16'(TICKS_PER_S)),
      .strict(1'b0),
      .hit(ul_hit)
   );
   // Stall must last longer than the set time, hence the strict compare
   persist_timer u_st_timer (
      .clk(SYS_CLK),
      .rst(RST),
      .cond(st_cond),
      .tick(tick_reg),
      .limit({5'h00, stall_max_time_reg}),
      .strict(1'b1),
      .hit(st_hit)
   );

   wire [ST_W-1:0] hits = {st_hit, ul_hit, ol_hit};
   wire [ST_W-1:0] det_rise = hits & ~hit_d_reg;

   // Reaction and restart hold-off, channel 0 overload, channel 1 underload
   wire [1:0] ch_hit = {ul_hit, ol_hit};
   wire [1:0] ch_rise = det_rise[1:0];
   wire [1:0] ch_react [2];
   wire [2:0] ch_delay [2];
   wire [1:0] ch_fault;
   assign ch_react[0] = overload_reaction_select_reg;
   assign ch_react[1] = underload_reaction_select_reg;
   assign ch_delay[0] = overload_restart_delay_reg;
   assign ch_delay[1] = underload_restart_delay_reg;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         mon_state_e state_reg;
         mon_state_e state_next;
         logic [11:0] hold_reg;
         wire [11:0] hold_need = 12'(ch_delay[g]) * 12'(TICKS_PER_MIN);
         wire hold_done = (hold_reg >= hold_need);
         wire reset_ok = ({1'b0, fault_reset_time_reg} >= (9'(ch_delay[g]) + 9'h001));
         assign ch_fault[g] = (state_reg != MON_RUN);
         always_comb begin
            state_next = state_reg;
            case (state_reg)
               MON_RUN: begin
                  if (ch_rise[g] && (ch_react[g] != REACT_IGNORE)) begin
                     state_next = MON_HALT;
                  end
               end
               MON_HALT: begin
                  if (hold_done && !ch_hit[g]) begin
                     state_next = reset_ok ? MON_RUN : MON_LOCK;
                  end
               end
               MON_LOCK: begin
                  if (lock_clr) begin
                     state_next = MON_RUN;
                  end
               end
               default: state_next = MON_RUN;
            endcase
         end
         always_ff @(posedge SYS_CLK) begin
            if (RST) begin
               state_reg <= MON_RUN;
               hold_reg <= 12'h000;
            end else begin
               state_reg <= state_next;
               if (state_reg != MON_HALT) begin
                  hold_reg <= 12'h000;
               end else if (tick_reg && (hold_reg != 12'hfff)) begin
                  hold_reg <= hold_reg + 12'h001;
               end
            end
         end
      end
   endgenerate

   // Stall error latches until software clears it once the condition has gone
   logic stall_err_reg;
   wire stall_err_next = det_rise[ST_STALL] || (stall_err_reg && !(lock_clr && !st_hit));

   // Stall wins, then overload, then underload
   wire [1:0] halt_next = stall_err_next ? REACT_FREEWHEEL :
      (ch_fault[0] ? overload_reaction_select_reg :
      (ch_fault[1] ? underload_reaction_select_reg : REACT_IGNORE));

   // A new event beats a write-one-to-clear in the same cycle
   wire [ST_W-1:0] status_next = det_rise | (status_reg & ~(wr_status ? wd[ST_W-1:0] : {ST_W{1'b0}}));

   wire [31:0] ctrl_word = {26'h0, 1'b0, stall_monitor_enable_reg, overload_reaction_select_reg,
      underload_reaction_select_reg};
   wire [31:0] restart_word = {16'h0, fault_reset_time_reg, 1'b0, overload_restart_delay_reg,
      1'b0, underload_restart_delay_reg};
   wire [31:0] state_word = {24'h0, steady, stall_err_reg, ch_fault, 1'b0, hits};
   wire [31:0] rd_mux =
      (rd_addr == A_CTRL) ? ctrl_word :
      (rd_addr == A_OVL_TIME) ? {25'h0, overload_detect_time_reg} :
      (rd_addr == A_OVL_THR) ? {24'h0, overload_current_threshold_reg} :
      (rd_addr == A_HYST) ? {19'h0, steady_state_hysteresis_reg} :
      (rd_addr == A_UL_TIME) ? {25'h0, underload_detect_time_reg} :
      (rd_addr == A_UL_FREQ) ? {19'h0, underload_min_freq_reg} :
      (rd_addr == A_RESTART) ? restart_word :
      (rd_addr == A_STALL_TIME) ? {21'h0, stall_max_time_reg} :
      (rd_addr == A_STALL_CUR) ? {21'h0, stall_current_threshold_reg} :
      (rd_addr == A_STALL_FREQ) ? {19'h0, stall_frequency_threshold_reg} :
      (rd_addr == A_RATED) ? {16'h0, rated_motor_current_reg} :
      (rd_addr == A_STATUS) ? {29'h0, status_reg} :
      (rd_addr == A_MASK) ? {29'h0, mask_reg} :
      (rd_addr == A_STATE) ? state_word : 32'h0000_0000;

   // Bus slave: zero wait states, read data sampled at the address phase
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= wr_req;
         wr_addr_reg <= HADDR[7:0];
         if (rd_req) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         pre_reg <= 24'h000000;
         tick_reg <= 1'b0;
      end else begin
         pre_reg <= pre_end ? 24'h000000 : pre_reg + 24'h000001;
         tick_reg <= pre_end;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         underload_reaction_select_reg <= REACT_FREEWHEEL;
         overload_reaction_select_reg <= REACT_FREEWHEEL;
         stall_monitor_enable_reg <= 1'b0;
      end else if (wr_ctrl) begin
         underload_reaction_select_reg <= ul_on ? wd[F_UL_REACT+:2] : underload_reaction_select_reg;
         overload_reaction_select_reg <= ol_on ? wd[F_OL_REACT+:2] : overload_reaction_select_reg;
         stall_monitor_enable_reg <= wd[F_STALL_EN];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         overload_detect_time_reg <= OVL_TIME_RST;
         overload_current_threshold_reg <= OVL_THR_RST;
         steady_state_hysteresis_reg <= HYST_RST;
         underload_detect_time_reg <= UL_TIME_RST;
         underload_min_freq_reg <= UL_FREQ_RST;
      end else begin
         if (ok_ovl_time) overload_detect_time_reg <= wd[6:0];
         if (ok_ovl_thr) overload_current_threshold_reg <= wd[7:0];
         if (ok_hyst) steady_state_hysteresis_reg <= wd[12:0];
         if (ok_ul_time) underload_detect_time_reg <= wd[6:0];
         if (ok_ul_freq) underload_min_freq_reg <= wd[12:0];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         underload_restart_delay_reg <= DELAY_RST;
         overload_restart_delay_reg <= DELAY_RST;
         fault_reset_time_reg <= RESET_TIME_RST;
         stall_max_time_reg <= STALL_TIME_RST;
         stall_current_threshold_reg <= STALL_CUR_RST;
         stall_frequency_threshold_reg <= STALL_FREQ_RST;
         rated_motor_current_reg <= RATED_RST;
      end else begin
         if (ok_ul_delay) underload_restart_delay_reg <= wd[F_UL_DELAY+:3];
         if (ok_ol_delay) overload_restart_delay_reg <= wd[F_OL_DELAY+:3];
         if (wr_restart) fault_reset_time_reg <= wd[F_RESET_TIME+:8];
         if (ok_st_time) stall_max_time_reg <= wd[10:0];
         if (ok_st_cur) stall_current_threshold_reg <= wd[10:0];
         if (ok_st_freq) stall_frequency_threshold_reg <= wd[12:0];
         if (wr_rated) rated_motor_current_reg <= wd[15:0];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         hit_d_reg <= 3'h0;
         status_reg <= 3'h0;
         mask_reg <= 3'h0;
         stall_err_reg <= 1'b0;
      end else begin
         hit_d_reg <= hits;
         status_reg <= status_next;
         if (wr_mask) mask_reg <= wd[ST_W-1:0];
         stall_err_reg <= stall_err_next;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         HALT_CODE <= REACT_IGNORE;
         OVERLOAD_FAULT <= 1'b0;
         UNDERLOAD_FAULT <= 1'b0;
         MOTOR_STALL_ERROR <= 1'b0;
         IRQ <= 1'b0;
         HRDATA <= 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         HALT_CODE <= halt_next;
         OVERLOAD_FAULT <= ch_fault[0];
         UNDERLOAD_FAULT <= ch_fault[1];
         MOTOR_STALL_ERROR <= stall_err_next;
         IRQ <= |(status_next & mask_reg);
         HRDATA <= rd_req ? rd_mux : rdata_reg;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end
endmodule

// File: sim/drive_core_model.sv
// Behavioural drive core feeding current, frequency and limitation state
`timescale 1ns/10ps
module drive_core_model (
   input wire logic [2:0] mode,
   output logic [15:0] current,
   output logic [15:0] freq,
   output logic [15:0] ref_freq,
   output logic clim,
   output logic torque_low
);
   always_comb begin
      case (mode)
         3'h1: {current, freq, ref_freq, clim, torque_low} = {16'h0320, 16'h00c8, 16'h01f4, 2'b10};
         // Overcurrent stays under the limit current so only the threshold trips
         3'h2: {current, freq, ref_freq, clim, torque_low} = {16'h05dc, 16'h01f4, 16'h01f4, 2'b00};
         3'h3: {current, freq, ref_freq, clim, torque_low} = {16'h04b0, 16'h0005, 16'h0005, 2'b00};
         3'h4: {current, freq, ref_freq, clim, torque_low} = {16'h012c, 16'h01f4, 16'h01f4, 2'b01};
         default: {current, freq, ref_freq, clim, torque_low} = {16'h01f4, 16'h01f4, 16'h01f4, 2'b00};
      endcase
   end
endmodule

// File: sim/plsm_assertions.sv
// Port-level checks for the load and stall monitor
`timescale 1ns/10ps
module plsm_assertions
   import plsm_pkg::*;
#(
   parameter int TICK_COUNT = 10
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic [15:0] MOTOR_CURRENT_MEASURED,
   input wire logic [15:0] MOTOR_OUTPUT_FREQ,
   input wire logic CURRENT_LIMIT_STATE,
   input wire logic [1:0] HALT_CODE,
   input wire logic OVERLOAD_FAULT,
   input wire logic UNDERLOAD_FAULT,
   input wire logic MOTOR_STALL_ERROR,
   input wire logic IRQ
);
   logic [15:0] up_reg;
   logic any_fault;
   assign any_fault = OVERLOAD_FAULT | UNDERLOAD_FAULT | MOTOR_STALL_ERROR;
   // Saturates so a long run cannot wrap back under the tick period
   always_ff @(posedge SYS_CLK) begin
      if (RST) up_reg <= 16'h0000;
      else if (up_reg != 16'hffff) up_reg <= up_reg + 16'h0001;
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   sequence s_fault_rise;
      $rose(any_fault);
   endsequence
   property p_okay; HREADYOUT && !HRESP; endproperty
   a_okay: assert property (p_okay) else $error("bus stalled or not okay");
   property p_reset_quiet; $past(RST) |-> HALT_CODE == 2'h0 && !IRQ && !any_fault; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
   property p_hrdata_hold; !(HSEL && HREADY && HTRANS[1] && !HWRITE) |=> $stable(HRDATA); endproperty
   a_hrdata_hold: assert property (p_hrdata_hold) else $error("read data moved without a read");
   property p_halt_fault; (HALT_CODE != 2'h0) == any_fault; endproperty
   a_halt_fault: assert property (p_halt_fault) else $error("halt code and faults disagree");
   property p_stall_free; MOTOR_STALL_ERROR |-> HALT_CODE == REACT_FREEWHEEL; endproperty
   a_stall_free: assert property (p_stall_free) else $error("stall halt is not freewheel");
   // No fault can be declared before one full persistence tick has elapsed
   property p_persist; s_fault_rise |-> up_reg >= TICK_COUNT; endproperty
   a_persist: assert property (p_persist) else $error("fault before first tick");
   property p_stall_cause; $rose(MOTOR_STALL_ERROR) |-> $past(MOTOR_OUTPUT_FREQ < {3'h0, MAX_FREQ}, 3); endproperty
   a_stall_cause: assert property (p_stall_cause) else $error("stall with high frequency");
   property p_ovl_cause;
      $rose(OVERLOAD_FAULT) |-> $past(CURRENT_LIMIT_STATE || MOTOR_CURRENT_MEASURED != 16'h0000, 3);
   endproperty
   a_ovl_cause: assert property (p_ovl_cause) else $error("overload without cause");
endmodule
bind process_load_stall_monitor plsm_assertions #(.TICK_COUNT(TICK_COUNT)) u_chk (.SYS_CLK(SYS_CLK), .RST(RST),
   .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .MOTOR_CURRENT_MEASURED(MOTOR_CURRENT_MEASURED), .MOTOR_OUTPUT_FREQ(MOTOR_OUTPUT_FREQ),
   .CURRENT_LIMIT_STATE(CURRENT_LIMIT_STATE), .HALT_CODE(HALT_CODE), .OVERLOAD_FAULT(OVERLOAD_FAULT),
   .UNDERLOAD_FAULT(UNDERLOAD_FAULT), .MOTOR_STALL_ERROR(MOTOR_STALL_ERROR), .IRQ(IRQ));

// File: sim/process_load_stall_monitor_test.sv
// Register-level bench for the load and stall monitor
`timescale 1ns/10ps
module process_load_stall_monitor_test
   import plsm_pkg::*;
();
   logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, hready, hresp, clim, tql, ovl, unl, stall, irq;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0, halt;
   logic [2:0] mode = 3'h0;
   logic [15:0] cur, frq, rfq;
   logic [7:0] ra [8] = '{A_CTRL, A_OVL_THR, A_HYST, A_RESTART, A_STALL_TIME, A_STALL_CUR, A_STALL_FREQ, 8'h3c};
   logic [31:0] rv [8] = '{32'h5, 32'h6e, 32'h3, 32'h500, 32'h258, 32'h5dc, 32'h14, 32'h0};
   int err_count = 0, checked = 0, cyc = 0;
   process_load_stall_monitor #(.TICK_COUNT(10)) i_dut (.SYS_CLK(clk), .RST(rst), .HSEL(1'b1), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .MOTOR_CURRENT_MEASURED(cur), .MOTOR_OUTPUT_FREQ(frq),
      .PRE_RAMP_REFERENCE_FREQ(rfq), .CURRENT_LIMIT_STATE(clim), .UNDERLOAD_TORQUE_LOW(tql), .HALT_CODE(halt),
      .OVERLOAD_FAULT(ovl), .UNDERLOAD_FAULT(unl), .MOTOR_STALL_ERROR(stall), .IRQ(irq));
   drive_core_model i_core (.mode(mode), .current(cur), .freq(frq), .ref_freq(rfq), .clim(clim), .torque_low(tql));
   initial forever #4 clk = ~clk;
   task automatic test_done();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(a, 1'b0, 32'h0, q);
      chk($sformatf("reg %h", a), e, q);
   endtask
   // Waits are bounded; a miss shows up in the comparison that follows.
   // One more edge, since channel faults and halt code trail the status bit by a cycle
   task automatic wait_irq();
      repeat (300) if (irq !== 1'b1) @(posedge clk);
      @(posedge clk);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 8; k++) rdc(ra[k], rv[k]);
      wr(A_OVL_THR, 32'h5a);
      rdc(A_OVL_THR, 32'h6e);
      wr(A_STALL_TIME, 32'h5);
      rdc(A_STALL_TIME, 32'h258);
      wr(A_RESTART, 32'h510);
      rdc(A_RESTART, 32'h500);
      wr(A_MASK, 32'h7);
      wr(A_CTRL, 32'h15);
      wr(A_STALL_TIME, 32'h5);
      wr(A_STALL_CUR, 32'h3e8);
      mode <= 3'h3;
      repeat (40) @(posedge clk);
      chk("stall early", 32'h0, stall);
      wait_irq();
      chk("stall halt", REACT_FREEWHEEL, halt);
      mode <= 3'h0;
      repeat (20) @(posedge clk);
      wr(A_CTRL, 32'h35);
      repeat (20) if (stall !== 1'b0) @(posedge clk);
      chk("stall clear", 32'h0, stall);
      wr(A_CTRL, 32'h5);
      wr(A_STATUS, 32'h7);
      wr(A_UL_TIME, 32'h1);
      wr(A_CTRL, 32'h7);
      mode <= 3'h4;
      wait_irq();
      chk("ul halt", QUICK_HALT_CODE, halt);
      chk("ul fault", 32'h1, unl);
      mode <= 3'h0;
      repeat (200) if (unl !== 1'b0) @(posedge clk);
      chk("ul restart", 32'h0, unl);
      wr(A_STATUS, 32'h7);
      wr(A_UL_FREQ, 32'h258);
      mode <= 3'h4;
      repeat (150) @(posedge clk);
      chk("ul low freq", 32'h0, irq);
      mode <= 3'h0;
      wr(A_CTRL, 32'h4);
      wr(A_RESTART, 32'h502);
      rdc(A_RESTART, 32'h500);
      wr(A_UL_TIME, 32'h0);
      wr(A_OVL_TIME, 32'h1);
      wr(A_OVL_THR, 32'h5a);
      wr(A_OVL_THR, 32'ha0);
      rdc(A_OVL_THR, 32'h5a);
      for (int r = 0; r < 4; r++) begin
         wr(A_CTRL, {28'h0, r[1:0], 2'h1});
         mode <= r[0] ? 3'h2 : 3'h1;
         repeat (80) @(posedge clk);
         chk("ovl early", 32'h0, irq);
         wait_irq();
         chk("ovl halt", {30'h0, r[1:0]}, halt);
         chk("ovl fault", {31'h0, r != 0}, ovl);
         mode <= 3'h0;
         repeat (200) if (ovl !== 1'b0) @(posedge clk);
         chk("ovl restart", 32'h0, ovl);
         wr(A_STATUS, 32'h1);
         rdc(A_STATUS, 32'h0);
      end
      // Reset time below delay plus one minute: the channel must stay locked until cleared
      wr(A_RESTART, 32'h0);
      mode <= 3'h1;
      wait_irq();
      mode <= 3'h0;
      repeat (50) @(posedge clk);
      chk("ovl lock", 32'h1, ovl);
      wr(A_CTRL, 32'h2d);
      repeat (2) @(posedge clk);
      chk("lock clear", 32'h0, ovl);
      test_done();
   end
endmodule
